// ### verilog/pcr_config_regs.sv
// Purpose: two protected configuration registers and the pin, power-good
//          and push-button logic that their fields steer
// Assumes: unlock_in comes from the password logic; nv_*_in hold the
//          stored power-up defaults
// Notes: analog fields leave as struct outputs for the analog blocks

`timescale 1ns/1ps

// What this block does
// - first register at 0x13, reset 0x08, protected
// - bit 7 picks 8 s or 15 s
// - bit 6 picks open-drain or push-pull pin two
// - bit 5 makes pin one steer pin two
// - bits 4:3 pick power-good delay, reset 01
// - delay only on power-good rise
// - bit 2 picks tight limits, overvoltage on
// - bits 1:0 pick lockout threshold, reset 00
// - second register 0x14, reset 0x40, bits 5:4 zero
// - bit 7 makes pin three warm reset input
// - bit 6 picks 200 or 400 mV hysteresis
// - bits 3:2 pick switch three current limit
// - bits 1:0 pick switch two current limit
// - pin-role bit overrides pin one, two enables
// - warm-reset bit overrides enable bit for pin three
module pcr_config_regs
  import pcr_pkg::*;
#(
  parameter int PGD_CYC0 = PGD_C0,
  parameter int PGD_CYC1 = PGD_C1,
  parameter int PGD_CYC2 = PGD_C2,
  parameter int PGD_CYC3 = PGD_C3,
  parameter int PB_CYC_SHORT = PB_SHORT_C,
  parameter int PB_CYC_LONG = PB_LONG_C
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic unlock_in,
  output logic [7:0] rdata_out,
  // stored power-up defaults
  input wire logic [7:0] nv_one_in,
  input wire logic [7:0] nv_two_in,
  // field outputs
  output pcr_cfg_one_s cfg_one_out,
  output pcr_cfg_two_s cfg_two_out,
  output logic loaded_out,
  // enable-register pin levels
  input wire pcr_pin_levels_s pin_levels_in,
  // io pin one
  input wire logic io_pin_one_in,
  output logic io_pin_one_out,
  output logic io_pin_one_oe_n_out,
  // output pin two
  output logic output_pin_two_out,
  output logic output_pin_two_oe_n_out,
  // io pin three
  input wire logic io_pin_three_in,
  output logic io_pin_three_out,
  output logic io_pin_three_oe_n_out,
  output logic buck12_warm_reset_out,
  // sequencing
  input wire logic pgood_raw_in,
  output logic power_good_out,
  input wire logic pb_held_in,
  output logic pb_reset_out
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pcr_state_e state; // load or run
  pcr_state_e next_state;
  pcr_cfg_one_s cfg_one; // first register
  pcr_cfg_one_s next_cfg_one;
  pcr_cfg_two_s cfg_two; // second register
  pcr_cfg_two_s next_cfg_two;
  logic [7:0] next_rdata;
  logic next_io1, next_io1_oe_n; // pin one
  logic next_out2, next_out2_oe_n; // pin two
  logic next_io3, next_io3_oe_n; // pin three
  logic next_warm;
  logic [HOLD_CW-1:0] pgd_limit; // power-good delay in cycles
  logic [HOLD_CW-1:0] pb_limit; // push-button hold in cycles
  logic wr_ok; // write accepted this cycle

  // writes need the load cycle over and the password path open
  assign wr_ok = (state == ST_RUN) && wr_in && unlock_in;
  // analog blocks take their settings straight from the registers
  assign cfg_one_out = cfg_one;
  assign cfg_two_out = cfg_two;
  assign loaded_out = (state == ST_RUN);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // first cycle after reset copies the stored defaults; later only
  // writes through the unlocked path change the registers
  always_comb begin
    next_state = ST_RUN;
    next_cfg_one = cfg_one;
    next_cfg_two = cfg_two;
    next_rdata = UNMAPPED_DATA;
    if (state == ST_LOAD) begin
      // stored defaults, reserved bits forced clear
      next_cfg_one = pcr_cfg_one_s'(nv_one_in);
      next_cfg_two = pcr_cfg_two_s'(nv_two_in & CFG_TWO_WMASK);
    end else if (wr_ok) begin
      case (addr_in)
        CFG_ONE_ADDR: begin
          next_cfg_one = pcr_cfg_one_s'(wdata_in);
        end
        CFG_TWO_ADDR: begin
          next_cfg_two = pcr_cfg_two_s'(wdata_in & CFG_TWO_WMASK);
        end
        default: begin
          next_cfg_one = cfg_one; // other addresses not ours
        end
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        CFG_ONE_ADDR: begin
          next_rdata = cfg_one;
        end
        CFG_TWO_ADDR: begin
          next_rdata = cfg_two & CFG_TWO_WMASK;
        end
        default: begin
          next_rdata = UNMAPPED_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_LOAD;
      cfg_one <= pcr_cfg_one_s'(CFG_ONE_RST);
      cfg_two <= pcr_cfg_two_s'(CFG_TWO_RST);
      rdata_out <= UNMAPPED_DATA;
    end else begin
      state <= next_state;
      cfg_one <= next_cfg_one;
      cfg_two <= next_cfg_two;
      rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // pin control
  // ----------------------------------------
  // an enable of low means the pin is driven
  always_comb begin
    // pin one: input when it steers pin two, else open-drain
    if (cfg_one.io1_role_select) begin
      next_io1 = 1'b0;
      next_io1_oe_n = 1'b1;
    end else begin
      next_io1 = 1'b0;
      next_io1_oe_n = pin_levels_in.io_pin_one;
    end
    // pin two level from pin one or from its enable bit
    if (cfg_one.io1_role_select) begin
      next_out2 = io_pin_one_in;
    end else begin
      next_out2 = pin_levels_in.output_pin_two;
    end
    // push-pull drives both levels; open-drain only pulls low
    if (cfg_one.out2_drive_type) begin
      next_out2_oe_n = 1'b0;
    end else begin
      next_out2_oe_n = next_out2;
      next_out2 = 1'b0;
    end
    // pin three: warm reset input or open-drain output
    if (cfg_two.buck12_warm_reset_enable) begin
      next_io3 = 1'b0;
      next_io3_oe_n = 1'b1;
      next_warm = !io_pin_three_in;
    end else begin
      next_io3 = 1'b0;
      next_io3_oe_n = pin_levels_in.io_pin_three;
      next_warm = 1'b0;
    end
  end

  // registered pads: a role change never glitches a pin
  // reset releases every pin; the load cycle drives them from the reset register values
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      io_pin_one_out <= 1'b0;
      io_pin_one_oe_n_out <= 1'b1;
      output_pin_two_out <= 1'b0;
      output_pin_two_oe_n_out <= 1'b1;
      io_pin_three_out <= 1'b0;
      io_pin_three_oe_n_out <= 1'b1;
      buck12_warm_reset_out <= 1'b0;
    end else begin
      io_pin_one_out <= next_io1;
      io_pin_one_oe_n_out <= next_io1_oe_n;
      output_pin_two_out <= next_out2;
      output_pin_two_oe_n_out <= next_out2_oe_n;
      io_pin_three_out <= next_io3;
      io_pin_three_oe_n_out <= next_io3_oe_n;
      buck12_warm_reset_out <= next_warm;
    end
  end

  // ----------------------------------------
  // power-good delay and push-button hold
  // ----------------------------------------
  // delay code to cycle count
  always_comb begin
    case (cfg_one.power_good_delay)
      2'b00: pgd_limit = HOLD_CW'(PGD_CYC0);
      2'b01: pgd_limit = HOLD_CW'(PGD_CYC1);
      2'b10: pgd_limit = HOLD_CW'(PGD_CYC2);
      default: pgd_limit = HOLD_CW'(PGD_CYC3);
    endcase
    pb_limit = cfg_one.pb_hold_long ? HOLD_CW'(PB_CYC_LONG)
                                    : HOLD_CW'(PB_CYC_SHORT);
  end

  // delayed on the rise, immediate on the fall
  pcr_hold_qual #(.CW(HOLD_CW)) u_pgood (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .level_in(pgood_raw_in),
    .limit_in(pgd_limit),
    .qualified_out(power_good_out)
  );

  // reset request once the button is held long enough
  pcr_hold_qual #(.CW(HOLD_CW)) u_pbhold (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .level_in(pb_held_in),
    .limit_in(pb_limit),
    .qualified_out(pb_reset_out)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // the release edge itself is not a load cycle: check from the next one
  nv_load_a: assert property (state == ST_LOAD && !sys_rst_in |=>
    cfg_one == $past(nv_one_in) && state == ST_RUN
      && cfg_two == pcr_cfg_two_s'($past(nv_two_in) & CFG_TWO_WMASK))
    else $error("stored default not loaded");
  locked_wr_a: assert property (state == ST_RUN && !unlock_in |=>
    $stable(cfg_one) && $stable(cfg_two))
    else $error("register changed while locked");
  cfg_one_wr_a: assert property (wr_ok && addr_in == CFG_ONE_ADDR
    |=> cfg_one == $past(wdata_in) ##1 rdata_out == UNMAPPED_DATA
      || $past(rd_in))
    else $error("write to first register lost");
  cfg_two_rd_a: assert property (rd_in && addr_in == CFG_TWO_ADDR
    |=> rdata_out == ($past(cfg_two) & CFG_TWO_WMASK)
      && rdata_out[5:4] == 2'b00)
    else $error("second register read wrong");
  rsvd_zero_a: assert property (cfg_two.reserved == 2'b00)
    else $error("reserved bits set");
  pin_one_a: assert property (cfg_one.io1_role_select |=>
    io_pin_one_oe_n_out && output_pin_two_out == ($past(io_pin_one_in)
      && $past(cfg_one.out2_drive_type)))
    else $error("pin one role ignored");
  push_pull_a: assert property (cfg_one.out2_drive_type |=>
    !output_pin_two_oe_n_out)
    else $error("push-pull pin two not driven");
  warm_reset_a: assert property (
    cfg_two.buck12_warm_reset_enable |=> io_pin_three_oe_n_out
      && buck12_warm_reset_out == !$past(io_pin_three_in))
    else $error("warm reset pin handled wrong");
  pgood_fall_a: assert property (!pgood_raw_in |=>
    !power_good_out)
    else $error("power-good fall delayed");
  // field writes reach the analog outputs unchanged
  cfg_one_fld_a: assert property (wr_ok && addr_in == CFG_ONE_ADDR
    |=> cfg_one_out.supervisor_tight_select == $past(wdata_in[2])
      && cfg_one_out.undervoltage_lockout_level == $past(wdata_in[1:0]))
    else $error("first register fields not written");
  cfg_two_wr_a: assert property (wr_ok && addr_in == CFG_TWO_ADDR
    |=> cfg_two_out.lockout_hysteresis == $past(wdata_in[6])
      && cfg_two_out.switch_three_current_limit == $past(wdata_in[3:2])
      && cfg_two_out.switch_two_current_limit == $past(wdata_in[1:0]))
    else $error("second register fields not written");

  // main scenarios
  pgood_rise_c: cover property ($rose(power_good_out));
  pb_reset_c: cover property ($rose(pb_reset_out));
  warm_c: cover property ($rose(buck12_warm_reset_out));
  wr_two_c: cover property (wr_ok && addr_in == CFG_TWO_ADDR);
  locked_c: cover property (state == ST_RUN && wr_in && !unlock_in);

endmodule // pcr_config_regs

// ### verilog/pcr_pkg.sv
// Purpose: shared constants and types of the configuration register pair
// Assumes: 25 MHz register clock, 8-bit register port
// Notes: struct member order gives each field's bit position, msb first

package pcr_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CFG_ONE_ADDR = 8'h13; // system_config_one
  localparam logic [7:0] CFG_TWO_ADDR = 8'h14; // system_config_two
  localparam logic [7:0] CFG_ONE_RST = 8'h08; // value held in reset
  localparam logic [7:0] CFG_TWO_RST = 8'h40; // value held in reset
  localparam logic [7:0] CFG_TWO_WMASK = 8'hCF; // bits 5:4 reserved
  localparam logic [7:0] UNMAPPED_DATA = 8'h00; // read of other address

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40; // mclk_in period
  localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  localparam int PGD_T0_MS = 10; // power-good delay codes 00..11
  localparam int PGD_T1_MS = 20;
  localparam int PGD_T2_MS = 50;
  localparam int PGD_T3_MS = 150;
  localparam int PB_SHORT_MS = 8000; // push-button hold, bit clear
  localparam int PB_LONG_MS = 15000; // push-button hold, bit set
  localparam int PGD_C0 = PGD_T0_MS * CYC_PER_MS;
  localparam int PGD_C1 = PGD_T1_MS * CYC_PER_MS;
  localparam int PGD_C2 = PGD_T2_MS * CYC_PER_MS;
  localparam int PGD_C3 = PGD_T3_MS * CYC_PER_MS;
  localparam int PB_SHORT_C = PB_SHORT_MS * CYC_PER_MS;
  localparam int PB_LONG_C = PB_LONG_MS * CYC_PER_MS;
  localparam int HOLD_CW = 29; // counter width, fits 375e6

  // ----------------------------------------
  // types
  // ----------------------------------------
  // first configuration register
  typedef struct packed {
    logic pb_hold_long; // 0 = 8 s, 1 = 15 s
    logic out2_drive_type; // 0 open-drain, 1 push-pull
    logic io1_role_select; // 1 = pin one steers pin two
    logic [1:0] power_good_delay; // 10/20/50/150 ms
    logic supervisor_tight_select; // tight limits, ov monitor on
    logic [1:0] undervoltage_lockout_level; // 2.75/2.95/3.25/3.35 V
  } pcr_cfg_one_s;

  // second configuration register
  typedef struct packed {
    logic buck12_warm_reset_enable; // pin three is warm reset in
    logic lockout_hysteresis; // 0 = 200 mV, 1 = 400 mV
    logic [1:0] reserved; // always zero
    logic [1:0] switch_three_current_limit; // 100/200/500/1000 mA
    logic [1:0] switch_two_current_limit; // 100/200/500/1000 mA
  } pcr_cfg_two_s;

  // level bits of the enable register that may drive the pins
  typedef struct packed {
    logic io_pin_three; // 0 drive low, 1 release
    logic output_pin_two; // 0 drive low, 1 release or high
    logic io_pin_one; // 0 drive low, 1 release
  } pcr_pin_levels_s;

  // load sequencer
  typedef enum logic [0:0] {
    ST_LOAD = 1'b0,
    ST_RUN = 1'b1
  } pcr_state_e;

endpackage

// ### verilog/pcr_hold_qual.sv
// Purpose: asserts its output once the input has stayed high long enough
// Assumes: limit_in is at least one
// Notes: output drops at once with the input; no delay on the way down

`timescale 1ns/1ps

module pcr_hold_qual #(
  parameter int CW = 29
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // qualifier
  input wire logic level_in,
  input wire logic [CW-1:0] limit_in,
  output logic qualified_out
);

  logic [CW-1:0] cnt; // high-time counter
  logic [CW-1:0] next_cnt;
  logic next_q;

  // ----------------------------------------
  // count high time
  // ----------------------------------------
  // restarts on any low cycle; saturates once the limit is met
  always_comb begin
    next_cnt = cnt;
    next_q = qualified_out;
    if (!level_in) begin
      next_cnt = '0;
      next_q = 1'b0;
    end else if (cnt >= limit_in - CW'(1)) begin
      next_q = 1'b1;
    end else begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt <= '0;
      qualified_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      qualified_out <= next_q;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  hold_drop_a: assert property (!level_in |=> !qualified_out)
    else $error("output stayed high after input fell");
  hold_early_a: assert property (
    level_in && !qualified_out && cnt < limit_in - CW'(1)
      |=> !qualified_out)
    else $error("output rose before the hold time");

endmodule // pcr_hold_qual

// ### sim/pcr_config_regs_bench.sv
// Purpose: self-checking bench for the configuration register pair
// Assumes: short delay counts set through the design parameters
// Notes: all inputs driven by non-blocking assignment at rising edges

`timescale 1ns/1ps

module pcr_config_regs_bench;
  import pcr_pkg::*;

  // ----------------------------------------
  // short counts
  // ----------------------------------------
  localparam int PGD_TAB [4] = '{3, 5, 7, 9}; // power-good delay per code
  localparam int PB_S = 12; // short push-button hold
  localparam int PB_L = 20; // long push-button hold

  // clock, reset and stimulus
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic unlock_in = 1'b0;
  logic [7:0] nv_one_in = CFG_ONE_RST;
  logic [7:0] nv_two_in = 8'h70; // reserved bits set on purpose
  pcr_pin_levels_s pin_levels_in = 3'h0;
  logic io_pin_one_in = 1'b0;
  logic io_pin_three_in = 1'b1;
  logic pgood_raw_in = 1'b0;
  logic pb_held_in = 1'b0;
  // design outputs
  logic [7:0] rdata_out;
  pcr_cfg_one_s cfg_one_out;
  pcr_cfg_two_s cfg_two_out;
  logic loaded_out, io_pin_one_out, io_pin_one_oe_n_out;
  logic output_pin_two_out, output_pin_two_oe_n_out;
  logic io_pin_three_out, io_pin_three_oe_n_out, buck12_warm_reset_out;
  logic power_good_out, pb_reset_out;
  // pin state packed for compact compares
  wire logic [7:0] pins = {2'h0, io_pin_three_out, io_pin_one_out,
    io_pin_one_oe_n_out, output_pin_two_oe_n_out, io_pin_three_oe_n_out,
    buck12_warm_reset_out};
  // bookkeeping
  int n_errors = 0;
  int n_tests = 0;
  int cyc_cnt = 0;

  always #20 mclk_in = ~mclk_in; // 25 MHz

  pcr_config_regs #(
    .PGD_CYC0(PGD_TAB[0]), .PGD_CYC1(PGD_TAB[1]), .PGD_CYC2(PGD_TAB[2]),
    .PGD_CYC3(PGD_TAB[3]), .PB_CYC_SHORT(PB_S), .PB_CYC_LONG(PB_L)
  ) u_pcr_config_regs (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .unlock_in(unlock_in), .rdata_out(rdata_out), .nv_one_in(nv_one_in),
    .nv_two_in(nv_two_in), .cfg_one_out(cfg_one_out),
    .cfg_two_out(cfg_two_out), .loaded_out(loaded_out),
    .pin_levels_in(pin_levels_in), .io_pin_one_in(io_pin_one_in),
    .io_pin_one_out(io_pin_one_out),
    .io_pin_one_oe_n_out(io_pin_one_oe_n_out),
    .output_pin_two_out(output_pin_two_out),
    .output_pin_two_oe_n_out(output_pin_two_oe_n_out),
    .io_pin_three_in(io_pin_three_in), .io_pin_three_out(io_pin_three_out),
    .io_pin_three_oe_n_out(io_pin_three_oe_n_out),
    .buck12_warm_reset_out(buck12_warm_reset_out),
    .pgood_raw_in(pgood_raw_in), .power_good_out(power_good_out),
    .pb_held_in(pb_held_in), .pb_reset_out(pb_reset_out)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic u);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    unlock_in <= u;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // one-cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask

  // let registered pin outputs follow their causes
  task automatic settle();
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  // raise a qualified input, count edges to output, then drop it
  task automatic rise(input int which, input int exp);
    int n;
    n = 0;
    @(posedge mclk_in);
    if (which == 0) pgood_raw_in <= 1'b1;
    else pb_held_in <= 1'b1;
    while (n < 100) begin
      @(posedge mclk_in);
      n++;
      #1;
      if ((which == 0 ? power_good_out : pb_reset_out) === 1'b1) break;
    end
    chk(n[7:0], exp[7:0]);
    @(posedge mclk_in);
    pgood_raw_in <= 1'b0;
    pb_held_in <= 1'b0;
    settle();
    chk({7'h0, power_good_out | pb_reset_out}, 8'h00);
  endtask

  // ----------------------------------------
  // timeout
  // ----------------------------------------
  always @(posedge mclk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    repeat (19) @(posedge mclk_in);
    #1;
    chk(cfg_one_out, CFG_ONE_RST);
    chk(cfg_two_out, CFG_TWO_RST);
    chk({7'h0, loaded_out}, 8'h00);
    @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk({7'h0, loaded_out}, 8'h01);
    rd(CFG_ONE_ADDR, 8'h08);
    rd(CFG_TWO_ADDR, 8'h40);
    $display("test reset done");
    // locked write ignored, unmapped read is zero
    wr(CFG_ONE_ADDR, 8'hFF, 1'b0);
    rd(CFG_ONE_ADDR, 8'h08);
    rd(8'h20, 8'h00);
    $display("test protect done");
    // second register fields, reserved bits dropped
    for (int k = 0; k < 4; k++) begin
      d = {k[1], k[0], 2'b11, k[1:0], k[1:0]};
      wr(CFG_TWO_ADDR, d, 1'b1);
      rd(CFG_TWO_ADDR, d & CFG_TWO_WMASK);
      chk(cfg_two_out.lockout_hysteresis, k[0]);
      chk(cfg_two_out.switch_three_current_limit, k[1:0]);
      chk(cfg_two_out.switch_two_current_limit, k[1:0]);
    end
    $display("test config two done");
    // first register fields and power-good delay per code
    for (int k = 0; k < 4; k++) begin
      d = {k[0], 2'b00, k[1:0], k[1], k[1:0]};
      wr(CFG_ONE_ADDR, d, 1'b1);
      rd(CFG_ONE_ADDR, d);
      chk(cfg_one_out.power_good_delay, k[1:0]);
      chk(cfg_one_out.supervisor_tight_select, k[1]);
      chk(cfg_one_out.undervoltage_lockout_level, k[1:0]);
      rise(0, PGD_TAB[k]);
    end
    $display("test power good done");
    // push-button hold time both ways
    wr(CFG_ONE_ADDR, 8'h08, 1'b1);
    rise(1, PB_S);
    wr(CFG_ONE_ADDR, 8'h88, 1'b1);
    #1;
    chk(cfg_one_out.pb_hold_long, 1'b1);
    rise(1, PB_L);
    $display("test push button done");
    // pins as open-drain general outputs
    wr(CFG_ONE_ADDR, 8'h00, 1'b1);
    wr(CFG_TWO_ADDR, 8'h00, 1'b1);
    settle();
    chk(pins, 8'h00);
    @(posedge mclk_in);
    pin_levels_in <= 3'b111;
    settle();
    chk(pins, 8'h0E);
    // push-pull pin two
    wr(CFG_ONE_ADDR, 8'h40, 1'b1);
    pin_levels_in <= 3'b010;
    settle();
    chk(pins, 8'h00);
    chk(output_pin_two_out, 1'b1);
    // pin one steers pin two, pin two enable bit ignored
    wr(CFG_ONE_ADDR, 8'h60, 1'b1);
    pin_levels_in <= 3'b101;
    io_pin_one_in <= 1'b1;
    settle();
    chk(pins, 8'h0A);
    chk(output_pin_two_out, 1'b1);
    @(posedge mclk_in);
    io_pin_one_in <= 1'b0;
    settle();
    chk(output_pin_two_out, 1'b0);
    // pin three as warm reset input
    wr(CFG_TWO_ADDR, 8'h80, 1'b1);
    pin_levels_in <= 3'b000;
    io_pin_three_in <= 1'b0;
    settle();
    chk(pins, 8'h0B);
    @(posedge mclk_in);
    io_pin_three_in <= 1'b1;
    settle();
    chk(pins, 8'h0A);
    $display("test pins done");
    // reset in mid-run loads new stored defaults
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    nv_one_in <= 8'hA5;
    nv_two_in <= 8'h3C;
    settle();
    chk({7'h0, loaded_out}, 8'h00);
    chk(cfg_one_out, CFG_ONE_RST);
    chk(cfg_two_out, CFG_TWO_RST);
    @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rd(CFG_ONE_ADDR, 8'hA5);
    rd(CFG_TWO_ADDR, 8'h0C);
    $display("test reload done");
    report_and_stop();
  end

endmodule // pcr_config_regs_bench
